// >>> verilog/lfdma_fetch.sv
// Frame-fetch DMA engine feeding the display FIFO.
// Assumes memory accepts a burst request by i_mem_ack then returns len words on i_mem_rvalid.
`timescale 1ns/1ps
`include "lfdma_regs.svh"

module lfdma_fetch (
	input wire logic i_clock, // 40 MHz system clock
	input wire logic i_resetn, // Async reset, active low
	input wire lfdma_pkg::lfdma_reg_req_t i_reg, // Register request
	output logic [31:0] o_rdata, // Read data, cycle after read strobe
	output lfdma_pkg::lfdma_mem_req_t o_mem, // Burst request
	input wire logic i_mem_ack, // Burst request taken
	input wire logic i_mem_rvalid, // Read word valid
	input wire logic [31:0] i_mem_rdata, // Read word
	input wire logic i_pix_rd, // Display pops a FIFO word
	output logic [31:0] o_pix_data, // FIFO head word
	output logic o_pix_valid, // FIFO not empty
	output logic o_busy, // Fetch in progress
	output logic o_irq // Level interrupt
);
	import lfdma_pkg::*;

	localparam int AW = `LFDMA_FIFO_AW;
	localparam int DEPTH = 1 << AW;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic pwr_q, pwr_d, en_q, en_d, rst_q, rst_d;
	logic [3:0] fetch_burst_length_q, fetch_burst_length_d;
	logic [31:0] frame_base_address_one_q, frame_base_address_one_d;
	logic [19:0] frm_words_q, frm_words_d;
	logic [1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
	logic [31:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic ev_under, ev_frame;

	// Register file; hardware set wins over software clear
	always_comb begin
		pwr_d = pwr_q;
		en_d = en_q;
		rst_d = 1'b0;
		fetch_burst_length_d = fetch_burst_length_q;
		frame_base_address_one_d = frame_base_address_one_q;
		frm_words_d = frm_words_q;
		irq_en_d = irq_en_q;
		irq_stat_d = irq_stat_q;
		rdata_d = 32'h0;
		if (i_reg.wr) begin
			case (i_reg.addr)
				`LFDMA_OFF_CTRL: begin
					pwr_d = i_reg.wdata[`LFDMA_CTRL_PWR];
					en_d = i_reg.wdata[`LFDMA_CTRL_EN];
					rst_d = i_reg.wdata[`LFDMA_CTRL_RST];
				end
				`LFDMA_OFF_CFG: fetch_burst_length_d = i_reg.wdata[3:0]; // [R6]
				`LFDMA_OFF_BASE: frame_base_address_one_d = {i_reg.wdata[31:2], 2'b00}; // [R7]
				`LFDMA_OFF_FRMWORDS: frm_words_d = i_reg.wdata[19:0];
				`LFDMA_OFF_IRQ_CLR: irq_stat_d = irq_stat_q & ~i_reg.wdata[1:0];
				`LFDMA_OFF_IRQ_EN: irq_en_d = i_reg.wdata[1:0];
				default: ;
			endcase
		end
		irq_stat_d[`LFDMA_IRQ_UNDER] = irq_stat_d[`LFDMA_IRQ_UNDER] | ev_under;
		irq_stat_d[`LFDMA_IRQ_FRAME] = irq_stat_d[`LFDMA_IRQ_FRAME] | ev_frame;
		if (i_reg.rd) begin
			case (i_reg.addr)
				`LFDMA_OFF_CTRL: rdata_d = {29'h0, 1'b0, en_q, pwr_q};
				`LFDMA_OFF_CFG: rdata_d = {28'h0, fetch_burst_length_q};
				`LFDMA_OFF_BASE: rdata_d = frame_base_address_one_q;
				`LFDMA_OFF_FRMWORDS: rdata_d = {12'h0, frm_words_q};
				`LFDMA_OFF_STATUS: rdata_d = {31'h0, o_busy};
				`LFDMA_OFF_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
				`LFDMA_OFF_IRQ_EN: rdata_d = {30'h0, irq_en_q};
				default: rdata_d = 32'h0;
			endcase
		end
		irq_d = |(irq_stat_d & irq_en_d);
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			pwr_q <= 1'b0;
			en_q <= 1'b0;
			rst_q <= 1'b0;
			fetch_burst_length_q <= `LFDMA_BURST_RESET;
			frame_base_address_one_q <= 32'h0;
			frm_words_q <= `LFDMA_FRMWORDS_RESET;
			irq_stat_q <= 2'h0;
			irq_en_q <= 2'h0;
			rdata_q <= 32'h0;
			irq_q <= 1'b0;
		end else begin
			pwr_q <= pwr_d;
			en_q <= en_d;
			rst_q <= rst_d;
			fetch_burst_length_q <= fetch_burst_length_d;
			frame_base_address_one_q <= frame_base_address_one_d;
			frm_words_q <= frm_words_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end
	assign o_rdata = rdata_q;
	assign o_irq = irq_q;

	// ----------------------------------------------------------------
	// Display FIFO
	// ----------------------------------------------------------------
	logic [31:0] mem_q [DEPTH];
	logic [AW:0] wp_q, wp_d, rp_q, rp_d;
	logic pwr_prev_q;
	logic fifo_wr, fifo_pop, fifo_empty;
	logic [31:0] head_q, head_d;
	logic hv_q, hv_d;

	assign fifo_empty = (wp_q == rp_q);
	assign fifo_wr = i_mem_rvalid && pwr_q;
	// Underflow: display wants a word while none is ready
	assign ev_under = pwr_q && i_pix_rd && !hv_q;

	// Pointers rewind on display power-up so no stale words remain
	always_comb begin
		wp_d = wp_q;
		rp_d = rp_q;
		fifo_pop = 1'b0;
		head_d = head_q;
		hv_d = hv_q;
		if (i_pix_rd && hv_q)
			hv_d = 1'b0;
		if (!hv_d && !fifo_empty) begin
			fifo_pop = 1'b1;
			head_d = mem_q[rp_q[AW-1:0]];
			hv_d = 1'b1;
			rp_d = rp_q + 1'b1;
		end
		if (fifo_wr)
			wp_d = wp_q + 1'b1;
		if (pwr_q && !pwr_prev_q) begin // [R2]
			wp_d = '0;
			rp_d = '0;
			hv_d = 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			wp_q <= '0;
			rp_q <= '0;
			pwr_prev_q <= 1'b0;
			head_q <= 32'h0;
			hv_q <= 1'b0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			pwr_prev_q <= pwr_q;
			head_q <= head_d;
			hv_q <= hv_d;
		end
	end

	// Storage has no reset; pointers guard stale content
	always_ff @(posedge i_clock) begin
		if (fifo_wr)
			mem_q[wp_q[AW-1:0]] <= i_mem_rdata;
	end
	assign o_pix_data = head_q;
	assign o_pix_valid = hv_q;

	// ----------------------------------------------------------------
	// Burst fetch engine
	// ----------------------------------------------------------------
	lfdma_state_t st_q, st_d;
	logic [31:0] addr_q, addr_d;
	logic [19:0] left_q, left_d;
	logic [4:0] cnt_q, cnt_d, len_q, len_d;
	logic en_prev_q, busy_q, busy_d, frame_q, frame_d, mem_valid_q, mem_valid_d, rewind;
	logic [AW:0] used;
	logic [10:0] to_bound, want;

	assign used = wp_q - rp_q;
	// Words left before the next 1-Kbyte boundary
	assign to_bound = `LFDMA_BOUNDARY_WORDS - {1'b0, addr_q[9:2]}; // [R5]
	assign want = {6'h0, fetch_burst_length_q} + 11'h1; // [R6]
	assign ev_frame = frame_q;
	// Pointer rewind this cycle; a start waits one cycle so the cut uses the rewound address
	assign rewind = (en_q && !en_prev_q) || rst_q;

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		left_d = left_q;
		cnt_d = cnt_q;
		len_d = len_q;
		frame_d = 1'b0;
		case (st_q)
			LFDMA_IDLE: begin
				if (en_q && pwr_q && !rewind && (DEPTH - 32'(used)) >= 32'(want)) begin
					len_d = (to_bound < want) ? to_bound[4:0] : want[4:0]; // [R5]
					if ({15'h0, len_d} > left_q)
						len_d = left_q[4:0];
					st_d = LFDMA_REQ;
				end
			end
			LFDMA_REQ: if (i_mem_ack) begin
				cnt_d = len_q;
				st_d = LFDMA_DATA;
			end
			LFDMA_DATA: if (i_mem_rvalid) begin
				cnt_d = cnt_q - 5'h1;
				addr_d = addr_q + 32'h4;
				left_d = left_q - 20'h1;
				if (cnt_q == 5'h1) begin
					st_d = LFDMA_IDLE;
					if (left_q == 20'h1) begin
						addr_d = frame_base_address_one_q;
						left_d = frm_words_q;
						frame_d = 1'b1;
					end
				end
			end
			default: st_d = LFDMA_IDLE;
		endcase
		// Rewind on enable or DMA reset; applies at once, even in the middle of a running burst
		if (rewind) begin // [R3]
			addr_d = frame_base_address_one_q; // [R7]
			left_d = frm_words_q;
		end
		busy_d = (st_d != LFDMA_IDLE); // [R11]
		mem_valid_d = (st_d == LFDMA_REQ);
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q <= LFDMA_IDLE;
			addr_q <= 32'h0;
			left_q <= 20'h0;
			cnt_q <= 5'h0;
			len_q <= 5'h0;
			en_prev_q <= 1'b0;
			busy_q <= 1'b0;
			mem_valid_q <= 1'b0;
			frame_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			left_q <= left_d;
			cnt_q <= cnt_d;
			len_q <= len_d;
			en_prev_q <= en_q;
			busy_q <= busy_d;
			mem_valid_q <= mem_valid_d;
			frame_q <= frame_d;
		end
	end
	assign o_busy = busy_q;
	// Request valid has its own flop so the output comes straight from a register
	assign o_mem = '{valid: mem_valid_q, addr: addr_q, len: len_q};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	burst_no_cross_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // [R5]
		o_mem.valid |-> ({22'h0, o_mem.addr[9:2]} + 32'(o_mem.len)) <= 32'h100)
		else $error("burst crosses 1K boundary");
	burst_len_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // [R6]
		o_mem.valid |-> o_mem.len <= 5'(fetch_burst_length_q) + 5'h1)
		else $error("burst longer than programmed");
	fifo_rewind_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // [R2]
		(pwr_q && !pwr_prev_q) |=> (wp_q == '0) && (rp_q == '0) && !hv_q)
		else $error("fifo pointers not rewound");
	addr_rewind_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // [R3]
		(en_q && !en_prev_q && st_q == LFDMA_IDLE) |=> addr_q == $past(frame_base_address_one_q))
		else $error("fetch pointer not rewound");
	busy_track_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // [R11]
		(st_q != LFDMA_IDLE) |-> o_busy)
		else $error("busy low during burst");
	idle_drop_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // [R11]
		(!en_q && st_q == LFDMA_IDLE) |=> !o_busy)
		else $error("busy stuck after disable");
	base_start_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // [R7]
		rst_q |=> addr_q == $past(frame_base_address_one_q))
		else $error("reset did not load base");
	irq_level_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		ev_under && irq_en_q[0] && !i_reg.wr |=> o_irq)
		else $error("underflow irq missing");
	burst_cov: cover property (@(posedge i_clock) disable iff (!i_resetn) o_mem.valid && i_mem_ack);
	split_cov: cover property (@(posedge i_clock) disable iff (!i_resetn) o_mem.valid && o_mem.len < 5'h10);
	frame_cov: cover property (@(posedge i_clock) disable iff (!i_resetn) ev_frame);
endmodule // lfdma_fetch

// >>> verilog/lfdma_regs.svh
// Register offsets, field positions, reset values and counts for the frame-fetch DMA.
// Assumes a plain byte-addressed register port and a 32-bit memory read bus.
//
// Behaviour
// R1 - After underflow, software resets both fetch pointers and display FIFO pointers.
// R2 - Display power off then on returns FIFO read and write pointers home.
// R3 - DMA disable then enable returns fetch address pointer to frame base.
// R4 - Recover: power off, disable, wait busy low, reset, power on, enable.
// R5 - Fetch uses bursts; no burst crosses a 1-Kbyte address boundary.
// R6 - Burst length field plus one gives 32-bit words per burst.
// R7 - Fetch starts from the programmed first frame base address register.
// R8 - Software aligns frame base address to the burst size.
// R9 - In 24-bit packed mode base offset is 0x30 multiple plus pixel start.
// R10 - Packed and burst alignment together restrict offsets further.
// R11 - Busy held while a burst is outstanding, cleared when idle after disable.
`ifndef LFDMA_REGS_SVH
`define LFDMA_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define LFDMA_OFF_CTRL 8'h00
`define LFDMA_OFF_CFG 8'h04
`define LFDMA_OFF_BASE 8'h08
`define LFDMA_OFF_FRMWORDS 8'h0C
`define LFDMA_OFF_STATUS 8'h10
`define LFDMA_OFF_IRQ_STAT 8'h14
`define LFDMA_OFF_IRQ_CLR 8'h18
`define LFDMA_OFF_IRQ_EN 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LFDMA_CTRL_PWR 0
`define LFDMA_CTRL_EN 1
`define LFDMA_CTRL_RST 2
`define LFDMA_IRQ_UNDER 0
`define LFDMA_IRQ_FRAME 1

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define LFDMA_BURST_RESET 4'hF
`define LFDMA_FRMWORDS_RESET 20'h00100
`define LFDMA_FIFO_AW 5
`define LFDMA_BOUNDARY_WORDS 11'h100

`endif

// >>> verilog/lfdma_pkg.sv
// Types shared by the frame-fetch DMA.
// Assumes the constants header is included by its users.
package lfdma_pkg;
	typedef enum logic [1:0] {LFDMA_IDLE, LFDMA_REQ, LFDMA_DATA} lfdma_state_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} lfdma_reg_req_t;

	// Memory burst read request
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [4:0] len;
	} lfdma_mem_req_t;
endpackage

// >>> verif/lfdma_mem_model.sv
// Behavioural system memory that answers burst reads from the frame-fetch DMA.
// Assumes one burst is outstanding at a time; each word returned equals its own byte address.
`timescale 1ns/1ps

module lfdma_mem_model (
	input wire logic i_clock, // System clock
	input wire logic i_resetn, // Async reset, active low
	input wire lfdma_pkg::lfdma_mem_req_t i_mem, // Burst request
	input wire logic i_slow, // Stretch ack and gap the words
	output logic o_ack, // Burst taken
	output logic o_rvalid, // Word valid
	output logic [31:0] o_rdata // Word
);
	import lfdma_pkg::*;
	logic [31:0] addr_q;
	logic [4:0] left_q;
	logic [1:0] dly_q;

	// ----------------------------------------
	// Burst responder
	// ----------------------------------------
	// Idle data is inverted every cycle so a stale word never passes for a fresh one
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ack <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			left_q <= 5'h0;
			dly_q <= 2'h0;
		end else begin
			o_ack <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= ~o_rdata;
			dly_q <= dly_q + 2'h1;
			if (left_q != 5'h0) begin
				if (!i_slow || dly_q[0]) begin
					o_rvalid <= 1'b1;
					o_rdata <= addr_q;
					addr_q <= addr_q + 32'h4;
					left_q <= left_q - 5'h1;
				end
			end else if (i_mem.valid && !o_ack && (!i_slow || dly_q == 2'h3)) begin
				o_ack <= 1'b1;
				addr_q <= i_mem.addr;
				left_q <= i_mem.len;
			end
		end
	end
endmodule // lfdma_mem_model

// >>> verif/testbench.sv
// Self-checking bench for the frame-fetch DMA: registers, interrupt, bursts and recovery.
// Assumes the memory model returns every word equal to its byte address.
`timescale 1ns/1ps
`include "lfdma_regs.svh"

module testbench;
	import lfdma_pkg::*;
	logic i_clock = 0, i_resetn = 0, i_pix_rd = 0, i_slow = 0, pop_on = 0, first = 0;
	lfdma_reg_req_t i_reg = '0;
	lfdma_mem_req_t o_mem;
	logic [31:0] o_rdata, o_pix_data, mdata, rdata, base, exp_a, ba;
	logic mem_ack, rvalid, o_pix_valid, o_busy, o_irq;
	logic [3:0] blen;
	int error_cnt = 0, total_checks = 0, pops = 0, seed = 77180, n;
	localparam logic [31:0] FRM = 32'h30;
	logic [7:0] ra [6] = '{`LFDMA_OFF_FRMWORDS, `LFDMA_OFF_CFG, `LFDMA_OFF_STATUS, `LFDMA_OFF_IRQ_STAT,
		`LFDMA_OFF_IRQ_CLR, 8'h20};
	logic [31:0] rv [6] = '{32'h100, 32'hF, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [3:0] cb [5] = '{4'hF, 4'h3, 4'hF, 4'h3, 4'hF};
	logic [31:0] co [5] = '{32'h0, 32'h30, 32'hC0, 32'h3F0, 32'h3F0};

	// ----------------------------------------
	// Clock, design and memory
	// ----------------------------------------
	initial forever #12.5 i_clock = ~i_clock;
	lfdma_fetch lfdma_fetch_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_reg(i_reg), .o_rdata(o_rdata),
		.o_mem(o_mem), .i_mem_ack(mem_ack), .i_mem_rvalid(rvalid), .i_mem_rdata(mdata), .i_pix_rd(i_pix_rd),
		.o_pix_data(o_pix_data), .o_pix_valid(o_pix_valid), .o_busy(o_busy), .o_irq(o_irq));
	lfdma_mem_model lfdma_mem_model_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_mem(o_mem),
		.i_slow(i_slow), .o_ack(mem_ack), .o_rvalid(rvalid), .o_rdata(mdata));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock) i_reg <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock) i_reg.wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock) i_reg <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock) i_reg.rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	// Words in the first burst: field plus one, cut at the 1 KB line
	function automatic logic [31:0] exp_len(input logic [31:0] a, input logic [3:0] b);
		logic [31:0] room;
		room = (32'h400 - {22'h0, a[9:0]}) >> 2;
		exp_len = (room < {28'h0, b} + 32'h1) ? room : {28'h0, b} + 32'h1;
	endfunction

	// Full recovery, then fetch 100 words from a new base
	task automatic restart(input logic [3:0] bl, input logic [31:0] b);
		logic [31:0] d;
		int k;
		pop_on = 0;
		@(posedge i_clock) i_pix_rd <= 1'b0;
		reg_wr(`LFDMA_OFF_CTRL, 32'h2); // Power off before disable
		reg_wr(`LFDMA_OFF_CTRL, 32'h0);
		d = 32'h1;
		for (k = 0; k < 200 && d[0]; k++) reg_rd(`LFDMA_OFF_STATUS, d); // Wait for idle
		chk(d, 32'h0, "busy stuck");
		reg_wr(`LFDMA_OFF_CTRL, 32'h4); // Reset fetch pointers too
		reg_wr(`LFDMA_OFF_CFG, {28'h0, bl});
		reg_wr(`LFDMA_OFF_BASE, b);
		base = b;
		blen = bl;
		exp_a = b;
		first = 1;
		pops = 0;
		reg_wr(`LFDMA_OFF_CTRL, 32'h1);
		reg_wr(`LFDMA_OFF_CTRL, 32'h3);
		pop_on = 1;
		for (k = 0; k < 5000 && pops < 100; k++) @(posedge i_clock);
		if (pops < 100) begin
			chk(pops, 100, "fetch timeout");
			complete_run;
		end
		reg_rd(`LFDMA_OFF_IRQ_STAT, d);
		chk({31'h0, d[1]}, 32'h1, "frame done flag");
		reg_wr(`LFDMA_OFF_IRQ_CLR, 32'h2);
		$display("test burst %0d base %h done", bl + 1, b);
	endtask

	// ----------------------------------------
	// Monitors of the fetch and display sides
	// ----------------------------------------
	always @(posedge i_clock) if (i_resetn && o_mem.valid && mem_ack) begin
		chk({31'h0, o_busy}, 32'h1, "busy low in burst");
		chk({31'h0, {22'h0, o_mem.addr[9:0]} + {25'h0, o_mem.len, 2'b0} <= 32'h400}, 32'h1, "1K cross");
		if (first) begin
			chk(o_mem.addr, base, "start address");
			chk({27'h0, o_mem.len}, exp_len(base, blen), "burst length");
			first = 0;
		end
	end

	// Pop every other cycle so a pop never meets an empty FIFO
	always @(posedge i_clock) if (pop_on) i_pix_rd <= o_pix_valid && !i_pix_rd;
	always @(posedge i_clock) if (pop_on && i_pix_rd && o_pix_valid) begin
		chk(o_pix_data, exp_a, "pixel word");
		exp_a = (exp_a + 32'h4 == base + (FRM << 2)) ? base : exp_a + 32'h4;
		pops++;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge i_clock);
		i_resetn <= 1'b1;
		for (n = 0; n < 6; n++) begin
			reg_rd(ra[n], rdata);
			chk(rdata, rv[n], "reset value");
		end
		$display("test reset values done");
		reg_wr(`LFDMA_OFF_FRMWORDS, FRM);
		reg_wr(`LFDMA_OFF_IRQ_EN, 32'h1);
		reg_wr(`LFDMA_OFF_CTRL, 32'h1); // Underflow is only seen with display power on
		@(posedge i_clock) i_pix_rd <= 1'b1;
		@(posedge i_clock) i_pix_rd <= 1'b0;
		reg_rd(`LFDMA_OFF_IRQ_STAT, rdata);
		chk({31'h0, rdata[0]}, 32'h1, "underflow flag");
		chk({31'h0, o_irq}, 32'h1, "irq raised");
		reg_wr(`LFDMA_OFF_IRQ_EN, 32'h0);
		reg_rd(`LFDMA_OFF_IRQ_EN, rdata);
		chk({31'h0, o_irq}, 32'h0, "irq masked");
		reg_wr(`LFDMA_OFF_IRQ_EN, 32'h1);
		reg_wr(`LFDMA_OFF_IRQ_CLR, 32'h1);
		reg_rd(`LFDMA_OFF_IRQ_STAT, rdata);
		chk({31'h0, rdata[0]}, 32'h0, "underflow cleared");
		chk({31'h0, o_irq}, 32'h0, "irq cleared");
		reg_wr(`LFDMA_OFF_IRQ_EN, 32'h0);
		$display("test interrupt done");
		for (n = 0; n < 5; n++) begin
			i_slow <= n[0];
			restart(cb[n], co[n]); // Aligned and packed-pixel bases, plus a boundary cut
		end
		for (n = 0; n < 4; n++) begin
			i_slow <= 1'($random(seed));
			blen = cb[n] >> n;
			ba = $random(seed) & 32'h000FFFFC & ~((({28'h0, blen} + 32'h1) << 2) - 32'h1);
			restart(blen, ba);
		end
		complete_run;
	end
endmodule // testbench
